// file: core/fnpc_ctrl.sv
// Flash controller: map, prefetch, write buffer, sequencer, NV bits
// What this block does
// - SRAM decodes at its base; after remap also at address zero.
// - Flash always at its base; aliased at zero until remap.
// - Array is 512 pages of 128 bytes in 32-bit words.
// - Flash writes fill a 128-byte page buffer, word by word.
// - Array enable drops to standby whenever nothing accesses it.
// - Registers set wait states, timing, launch commands, show status.
// - Two prefetch words serve consecutive fetches without array reads.
// - Sixteen lock bits, each guarding 32 pages, 4 Kbytes.
// - Program or erase command on a locked region aborts untouched and flags error.
// - Set-lock and clear-lock commands change the addressed region.
// - Wipe pin clears all sixteen lock bits.
// - Security bit refuses debug and programming port accesses.
// - Security set by command; cleared by wipe plus full erase.
// - Two general NV bits, set and cleared by own commands.
// - General bit 0 enables brownout detector; wipe clears it.
// - General bit 1 enables brownout reset; wipe clears it.
// - Eight calibration bits fixed; no command or wipe alters them.
// - Fast port offers program, erase, lock, unlock, protect.
// - Array reads insert zero to three programmable wait states.
// - APB commands start only when written with the correct key.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "fnpc_defines.svh"
module fnpc_ctrl #(
  parameter int unsigned PROG_CYC  =
    (`FNPC_PROG_NS + `FNPC_CLK_NS - 1) / `FNPC_CLK_NS,
  parameter int unsigned ERASE_CYC =
    (`FNPC_ERASE_NS + `FNPC_CLK_NS - 1) / `FNPC_CLK_NS
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    sys_req,
  input  fnpc_pkg::fnpc_sys_req_t      sys_in,
  output logic                         sys_ack,
  output logic                         sys_err,
  output logic [31:0]                  sys_rdata,
  output logic                         dec_sram,
  output logic                         dec_flash,
  input  wire logic                    fpp_valid,
  input  fnpc_pkg::fnpc_cmd_t          fpp_cmd,
  output logic                         fpp_ready,
  output logic                         fpp_mode,
  output logic                         arr_en,
  output logic                         arr_rd,
  output logic                         arr_we,
  output logic                         arr_erase,
  output logic                         arr_all,
  output logic [13:0]                  arr_addr,
  output logic [31:0]                  arr_wdata,
  input  wire logic [31:0]             arr_rdata,
  input  fnpc_pkg::fnpc_nv_t           nv_init,
  output fnpc_pkg::fnpc_nv_t           nv_out,
  input  wire logic                    wipe_pin,
  input  wire logic                    test_mode_pin,
  input  wire logic                    port_line_zero,
  input  wire logic                    port_line_one,
  output logic                         brownout_detector_en,
  output logic                         brownout_reset_en,
  output logic                         irq
);
  import fnpc_pkg::*;

  localparam fnpc_cnt_t PROG_LIM  = fnpc_cnt_t'(PROG_CYC - 1);
  localparam fnpc_cnt_t ERASE_LIM = fnpc_cnt_t'(ERASE_CYC - 1);

  fnpc_state_t state_r;
  fnpc_cnt_t   cnt_r;
  fnpc_cmd_t   cmd_r;
  fnpc_nv_t    nv_r;
  logic [31:0] mode_r;
  logic [31:0] wbuf_r [32];
  logic [31:0] pf_r [2];
  logic [12:0] pf_tag_r;
  logic        pf_vld_r;
  logic [3:0]  pin_s1_r;
  logic [3:0]  pin_s2_r;
  logic        wipe_d_r;
  logic        wipe_pend_r;
  logic        ld_r;
  logic        remap_r;
  logic        busy_r;
  logic        go_r;
  logic        done_r;
  logic        lockerr_r;
  logic        keyerr_r;
  logic        sys_ack_r;
  logic        sys_err_r;
  logic [31:0] sys_rdata_r;
  logic [31:0] prdata_nxt;
  logic        apb_wr;
  logic        apb_rd;
  logic        cmd_wr;
  logic        key_ok;
  logic        acc_apb;
  logic        acc_fpp;
  logic        acc_wipe;
  logic        wipe_rise;
  logic        locked_w;
  logic        abort_w;
  logic        fin_w;
  logic        nv_apply;
  logic        hit_w;
  logic        take_w;
  logic        refuse_w;
  logic [31:0] area_w;
  logic [1:0]  ws_w;

  // Pins from outside the clock domain: two stages before use
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end
    else
    begin
      pin_s1_r <= {wipe_pin, test_mode_pin, port_line_zero, port_line_one};
      pin_s2_r <= pin_s1_r;
    end

  assign fpp_mode  = &pin_s2_r[2:0];
  assign wipe_rise = pin_s2_r[3] & ~wipe_d_r;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wipe_d_r <= 1'b0;
    else
      wipe_d_r <= pin_s2_r[3];

  // Address map
  assign area_w = sys_in.addr & `FNPC_AREA_MASK;
  assign dec_sram  = (area_w == `FNPC_SRAM_BASE) |
                     (remap_r & (area_w == `FNPC_BOOT_BASE));
  assign dec_flash = (area_w == `FNPC_FLASH_BASE) |
                     (~remap_r & (area_w == `FNPC_BOOT_BASE));

  // APB slave, zero wait states
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign cmd_wr = apb_wr & (paddr == `FNPC_OFS_CMD);
  assign key_ok = pwdata[`FNPC_F_KEY] == `FNPC_KEY;
  assign ws_w   = mode_r[`FNPC_F_WS];

  always_comb
  begin
    prdata_nxt = 32'h0;
    pslverr    = 1'b0;
    unique case (paddr)
      `FNPC_OFS_MODE: prdata_nxt = mode_r;
      `FNPC_OFS_CMD:  prdata_nxt = {19'h0, cmd_r};
      `FNPC_OFS_STAT:
      begin
        prdata_nxt[`FNPC_S_RDY]   = ~busy_r;
        prdata_nxt[`FNPC_S_DONE]  = done_r;
        prdata_nxt[`FNPC_S_LOCKE] = lockerr_r;
        prdata_nxt[`FNPC_S_KEYE]  = keyerr_r;
        prdata_nxt[`FNPC_S_SEC]   = nv_r.sec;
        prdata_nxt[`FNPC_S_FPP]   = fpp_mode;
      end
      `FNPC_OFS_LOCK: prdata_nxt = {16'h0, nv_r.lock};
      `FNPC_OFS_NVM:
      begin
        prdata_nxt[`FNPC_N_GP]  = nv_r.gp;
        prdata_nxt[`FNPC_N_SEC] = nv_r.sec;
        prdata_nxt[`FNPC_N_CAL] = nv_r.cal;
      end
      default: pslverr = psel & penable;
    endcase
  end

  assign prdata = apb_rd ? prdata_nxt : 32'h0;

  // Mode register; remap is write-once until reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mode_r  <= `FNPC_MODE_RST;
      remap_r <= 1'b0;
    end
    else if (apb_wr && paddr == `FNPC_OFS_MODE)
    begin
      mode_r  <= pwdata;
      remap_r <= remap_r | pwdata[`FNPC_F_REMAP];
    end

  // Command intake: wipe first, then APB, then fast port
  assign acc_wipe = wipe_pend_r & ~busy_r;
  assign acc_apb  = cmd_wr & key_ok & ~busy_r & ~wipe_pend_r;
  assign acc_fpp  = fpp_valid & fpp_ready;
  // Secured part refuses every fast port command
  assign fpp_ready = fpp_mode & ~busy_r & ~wipe_pend_r & ~cmd_wr &
                     ~nv_r.sec;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cmd_r  <= '0;
      go_r   <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      if (acc_wipe)
        cmd_r <= '{op: `FNPC_OP_EA, page: 9'h0};
      else if (acc_apb)
        cmd_r <= '{op: pwdata[`FNPC_F_OP], page: pwdata[`FNPC_F_PAGE]};
      else if (acc_fpp)
        cmd_r <= fpp_cmd;
      if (acc_wipe || acc_apb || acc_fpp)
      begin
        go_r   <= 1'b1;
        busy_r <= 1'b1;
      end
      else
      begin
        if (state_r == ST_IDLE)
          go_r <= 1'b0;
        if (fin_w)
          busy_r <= 1'b0;
      end
    end

  // Region of a page is its top four bits
  always_comb
  begin
    locked_w = 1'b0;
    unique case (cmd_r.op)
      `FNPC_OP_WP, `FNPC_OP_PE:
        locked_w = nv_r.lock[cmd_r.page[8:5]];
      `FNPC_OP_EA:
        locked_w = (|nv_r.lock) & ~wipe_pend_r;
      default: locked_w = 1'b0;
    endcase
  end

  assign abort_w  = (state_r == ST_IDLE) & go_r & locked_w;
  assign nv_apply = (state_r == ST_NVMOP) &
                    (cnt_r[7:0] == mode_r[`FNPC_F_TICK]);
  assign fin_w = abort_w | nv_apply |
                 ((state_r == ST_PROG) & (cnt_r == PROG_LIM)) |
                 ((state_r == ST_ERASE) &
                  (cnt_r == (cmd_r.op == `FNPC_OP_EA ? ERASE_LIM : PROG_LIM)));

  // Status flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      done_r    <= 1'b0;
      lockerr_r <= 1'b0;
      keyerr_r  <= 1'b0;
    end
    else
    begin
      done_r    <= fin_w |
                   (done_r & ~(apb_rd && paddr == `FNPC_OFS_STAT));
      lockerr_r <= abort_w |
                   (lockerr_r & ~(apb_rd && paddr == `FNPC_OFS_STAT));
      keyerr_r  <= (cmd_wr & ~key_ok) |
                   (keyerr_r & ~(apb_rd && paddr == `FNPC_OFS_STAT));
    end

  assign irq = (done_r & mode_r[`FNPC_F_IEDONE]) |
               ((lockerr_r | keyerr_r) & mode_r[`FNPC_F_IEERR]);

  // Non-volatile bits: taken from the cells once after reset release
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ld_r <= 1'b0;
    else
      ld_r <= 1'b1;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      nv_r        <= '0;
      wipe_pend_r <= 1'b0;
    end
    else if (!ld_r)
      nv_r <= nv_init;
    else
    begin
      if (wipe_rise)
      begin
        nv_r.lock   <= 16'h0;
        nv_r.gp     <= 2'h0;
        wipe_pend_r <= 1'b1;
      end
      else if (fin_w && cmd_r.op == `FNPC_OP_EA && wipe_pend_r)
      begin
        nv_r.sec    <= 1'b0;
        wipe_pend_r <= 1'b0;
      end
      // A wipe in the same cycle must not be undone by a set command
      if (nv_apply && !wipe_rise)
        unique case (cmd_r.op)
          `FNPC_OP_SLB: nv_r.lock[cmd_r.page[8:5]] <= 1'b1;
          `FNPC_OP_CLB: nv_r.lock[cmd_r.page[8:5]] <= 1'b0;
          `FNPC_OP_SGP: nv_r.gp[cmd_r.page[0]] <= 1'b1;
          `FNPC_OP_CGP: nv_r.gp[cmd_r.page[0]] <= 1'b0;
          `FNPC_OP_SSB: nv_r.sec <= 1'b1;
          default: nv_r.sec <= nv_r.sec;
        endcase
    end

  assign nv_out = nv_r;
  assign brownout_detector_en = nv_r.gp[0];
  assign brownout_reset_en    = nv_r.gp[1];

  // System bus side
  assign take_w = (state_r == ST_IDLE) & ~go_r & sys_req & dec_flash &
                  ~sys_ack_r;
  assign refuse_w = sys_in.dbg & nv_r.sec;
  assign hit_w = pf_vld_r & (pf_tag_r == sys_in.addr[15:3]);

  // Page buffer, one word per write; no reset, software fills it
  always_ff @(posedge pclk)
    if (take_w && !refuse_w && sys_in.we)
      wbuf_r[sys_in.addr[6:2]] <= sys_in.wdata;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_r     <= ST_IDLE;
      cnt_r       <= '0;
      sys_ack_r   <= 1'b0;
      sys_err_r   <= 1'b0;
      sys_rdata_r <= 32'h0;
      pf_vld_r    <= 1'b0;
      pf_tag_r    <= 13'h0;
      pf_r[0]     <= 32'h0;
      pf_r[1]     <= 32'h0;
    end
    else
    begin
      sys_ack_r <= 1'b0;
      sys_err_r <= 1'b0;
      cnt_r     <= cnt_r + fnpc_cnt_t'(1);
      unique case (state_r)
        ST_IDLE:
        begin
          cnt_r <= '0;
          if (go_r && !locked_w)
            unique case (cmd_r.op)
              `FNPC_OP_WP: state_r <= ST_PROG;
              `FNPC_OP_PE, `FNPC_OP_EA: state_r <= ST_ERASE;
              default: state_r <= ST_NVMOP;
            endcase
          else if (take_w)
          begin
            if (refuse_w || sys_in.we || hit_w)
            begin
              sys_ack_r   <= 1'b1;
              sys_err_r   <= refuse_w;
              sys_rdata_r <= (refuse_w || sys_in.we) ? 32'h0 :
                             pf_r[sys_in.addr[2]];
            end
            else
              state_r <= ST_RD0;
          end
        end
        // Each word takes wait states plus one cycle
        ST_RD0:
          if (cnt_r[1:0] == ws_w)
          begin
            pf_r[0]  <= arr_rdata;
            pf_vld_r <= 1'b0;
            cnt_r    <= '0;
            state_r  <= ST_RD1;
          end
        ST_RD1:
          if (cnt_r[1:0] == ws_w)
          begin
            pf_r[1]  <= arr_rdata;
            pf_tag_r <= sys_in.addr[15:3];
            pf_vld_r <= 1'b1;
            state_r  <= ST_RACK;
          end
        ST_RACK:
        begin
          sys_ack_r   <= 1'b1;
          sys_rdata_r <= pf_r[sys_in.addr[2]];
          state_r     <= ST_IDLE;
        end
        ST_PROG, ST_ERASE:
          if (fin_w)
          begin
            pf_vld_r <= 1'b0;  // Stale words must not survive a rewrite
            state_r  <= ST_IDLE;
          end
        ST_NVMOP:
          if (fin_w)
            state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end

  assign sys_ack   = sys_ack_r;
  assign sys_err   = sys_err_r;
  assign sys_rdata = sys_rdata_r;

  // Array port; enable low outside accesses puts it in standby
  assign arr_rd    = (state_r == ST_RD0) | (state_r == ST_RD1);
  assign arr_we    = (state_r == ST_PROG) &
                     (cnt_r <= fnpc_cnt_t'(`FNPC_PAGE_WORDS));
  assign arr_erase = state_r == ST_ERASE;
  assign arr_all   = arr_erase & (cmd_r.op == `FNPC_OP_EA);
  assign arr_en    = arr_rd | arr_we | arr_erase;
  assign arr_addr  = arr_rd ?
                     {sys_in.addr[15:3], state_r == ST_RD1} :
                     {cmd_r.page, cnt_r[4:0]};
  assign arr_wdata = wbuf_r[cnt_r[4:0]];

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sram_remap: assert property (
    remap_r && area_w == `FNPC_BOOT_BASE |-> dec_sram && !dec_flash)
    else $error("sram not at zero after remap");
  a_flash_alias: assert property (
    !remap_r && area_w == `FNPC_BOOT_BASE |-> dec_flash && !dec_sram)
    else $error("flash not at zero before remap");
  a_array_standby: assert property (
    state_r == ST_IDLE || state_r == ST_RACK |-> !arr_en)
    else $error("array enabled while idle");
  a_lock_abort: assert property (
    abort_w |=> state_r == ST_IDLE && lockerr_r && !arr_we && !arr_erase)
    else $error("locked command not aborted");
  a_key_guard: assert property (
    cmd_wr && !key_ok && !busy_r && !wipe_pend_r && !fpp_valid |=> !go_r)
    else $error("command started without key");
  a_secure_refuse: assert property (
    take_w && refuse_w |=> sys_ack_r && sys_err_r && sys_rdata_r == 32'h0)
    else $error("secured debug access not refused");
  a_wipe_clear: assert property (
    ld_r && wipe_rise |=> nv_r.lock == 16'h0 && nv_r.gp == 2'h0)
    else $error("wipe left protection bits");
  a_wait_three: assert property (
    $rose(state_r == ST_RD0) && ws_w == 2'h3 && $stable(ws_w)
    |-> (state_r == ST_RD0) [*4] ##1 state_r == ST_RD1)
    else $error("wait states wrong");
  a_prefetch_hit: assert property (
    take_w && !go_r && hit_w && !refuse_w && !sys_in.we
    |=> sys_ack_r && state_r == ST_IDLE && !arr_rd)
    else $error("prefetch hit read the array");
  a_busy_shown: assert property (
    state_r == ST_PROG || state_r == ST_ERASE || state_r == ST_NVMOP
    |-> busy_r)
    else $error("busy not shown");
  a_cal_fixed: assert property (
    ld_r && $past(ld_r) |-> $stable(nv_r.cal))
    else $error("calibration bits changed");

  c_page_prog: cover property (state_r == ST_PROG && fin_w);
  c_prefetch_hit: cover property (take_w && hit_w && !sys_in.we);
  c_wipe_unlock: cover property ($fell(nv_r.sec));
endmodule

// file: core/fnpc_defines.svh
// Constants of the flash protection controller
`ifndef FNPC_DEFINES_SVH
`define FNPC_DEFINES_SVH
`define FNPC_AREA_MASK  32'hfff0_0000
`define FNPC_SRAM_BASE  32'h0020_0000
`define FNPC_FLASH_BASE 32'h0010_0000
`define FNPC_BOOT_BASE  32'h0000_0000
`define FNPC_OFS_MODE   8'h00
`define FNPC_OFS_CMD    8'h04
`define FNPC_OFS_STAT   8'h08
`define FNPC_OFS_LOCK   8'h0c
`define FNPC_OFS_NVM    8'h10
`define FNPC_F_WS       1:0
`define FNPC_F_IEDONE   8
`define FNPC_F_IEERR    9
`define FNPC_F_REMAP    12
`define FNPC_F_TICK     23:16
`define FNPC_F_KEY      31:24
`define FNPC_F_PAGE     16:8
`define FNPC_F_OP       3:0
`define FNPC_S_RDY      0
`define FNPC_S_DONE     1
`define FNPC_S_LOCKE    2
`define FNPC_S_KEYE     3
`define FNPC_S_SEC      4
`define FNPC_S_FPP      5
`define FNPC_N_GP       1:0
`define FNPC_N_SEC      8
`define FNPC_N_CAL      23:16
`define FNPC_MODE_RST   32'h000f_0000
`define FNPC_KEY        8'ha5
`define FNPC_OP_WP      4'h1
`define FNPC_OP_PE      4'h2
`define FNPC_OP_EA      4'h3
`define FNPC_OP_SLB     4'h4
`define FNPC_OP_CLB     4'h5
`define FNPC_OP_SGP     4'h6
`define FNPC_OP_CGP     4'h7
`define FNPC_OP_SSB     4'h8
`define FNPC_PAGE_WORDS 5'h1f
`define FNPC_CLK_NS     40
`define FNPC_PROG_NS    4000000
`define FNPC_ERASE_NS   10000000
`endif

// file: core/fnpc_pkg.sv
// Types of the flash protection controller
package fnpc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RD0   = 3'h1,
    ST_RD1   = 3'h3,
    ST_RACK  = 3'h2,
    ST_PROG  = 3'h6,
    ST_ERASE = 3'h7,
    ST_NVMOP = 3'h5
  } fnpc_state_t;
  typedef logic [17:0] fnpc_cnt_t;
  typedef struct packed {
    logic        we;
    logic        dbg;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fnpc_sys_req_t;
  typedef struct packed {
    logic [3:0] op;
    logic [8:0] page;
  } fnpc_cmd_t;
  typedef struct packed {
    logic [15:0] lock;
    logic [1:0]  gp;
    logic        sec;
    logic [7:0]  cal;
  } fnpc_nv_t;
endpackage

// file: verif/fnpc_flash_model.sv
// Behavioural flash array behind the controller's array pins
`timescale 1ns/10ps
module fnpc_flash_model (
  input  wire logic        pclk,
  input  wire logic        arr_rd,
  input  wire logic        arr_we,
  input  wire logic        arr_erase,
  input  wire logic        arr_all,
  input  wire logic [13:0] arr_addr,
  input  wire logic [31:0] arr_wdata,
  output logic      [31:0] arr_rdata
);
  logic [31:0] mem [0:16383];
  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = 32'hffff_ffff;
  end
  always @(posedge pclk)
  begin
    if (arr_we)
      mem[arr_addr] <= arr_wdata;
    if (arr_erase)
      for (int i = 0; i < 16384; i++)
        if (arr_all || i[13:5] == arr_addr[13:5])
          mem[i] <= 32'hffff_ffff;
  end
  // Outside a read the bus shows junk, so stale data cannot pass
  assign arr_rdata = arr_rd ? mem[arr_addr] : ~mem[arr_addr];
endmodule

// file: verif/flash_nvm_protection_control_tb_top.sv
// Self-checking bench for the flash protection controller
`timescale 1ns/10ps
`include "fnpc_defines.svh"
module flash_nvm_protection_control_tb_top;
  import fnpc_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, sys_rdata, arr_wdata, arr_rdata;
  logic          sys_req, sys_ack, sys_err, dec_sram, dec_flash;
  fnpc_sys_req_t sys_in;
  fnpc_cmd_t     fpp_cmd;
  fnpc_nv_t      nv_init, nv_out;
  logic          fpp_valid, fpp_ready, fpp_mode, arr_en, arr_rd, arr_we;
  logic          arr_erase, arr_all, wipe_pin, test_mode_pin, irq;
  logic          port_line_zero, port_line_one, bod_en, bor_en, e;
  logic [13:0]   arr_addr;
  logic [31:0]   r, s, seed, d;
  logic [31:0]   bufw [0:31];
  logic [15:0]   m_lock;
  logic [1:0]    m_gp;
  int            n_errors, tests_run, k;
  localparam logic [31:0] FB = `FNPC_FLASH_BASE;
  localparam logic [7:0]  CAL = 8'h5a;

  fnpc_ctrl #(.PROG_CYC(40), .ERASE_CYC(60)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_req(sys_req), .sys_in(sys_in),
    .sys_ack(sys_ack), .sys_err(sys_err), .sys_rdata(sys_rdata),
    .dec_sram(dec_sram), .dec_flash(dec_flash), .fpp_valid(fpp_valid),
    .fpp_cmd(fpp_cmd), .fpp_ready(fpp_ready), .fpp_mode(fpp_mode),
    .arr_en(arr_en), .arr_rd(arr_rd), .arr_we(arr_we),
    .arr_erase(arr_erase), .arr_all(arr_all), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .nv_init(nv_init),
    .nv_out(nv_out), .wipe_pin(wipe_pin), .test_mode_pin(test_mode_pin),
    .port_line_zero(port_line_zero), .port_line_one(port_line_one),
    .brownout_detector_en(bod_en), .brownout_reset_en(bor_en), .irq(irq));

  fnpc_flash_model u_arr (.pclk(pclk), .arr_rd(arr_rd), .arr_we(arr_we),
    .arr_erase(arr_erase), .arr_all(arr_all), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_rdata(arr_rdata));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task summarize;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Entered just after a rising edge; holds the request until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task cmd(input logic [3:0] op, input logic [8:0] pg, input logic [7:0] ky);
    apb(1'b1, `FNPC_OFS_CMD, {ky, 7'h00, pg, 4'h0, op});
  endtask

  // Status read clears the sticky flags, so the last read is returned
  task wait_rdy;
    s = 32'h0;
    for (k = 0; k < 400 && s[0] !== 1'b1; k++)
    begin
      apb(1'b0, `FNPC_OFS_STAT, 32'h0);
      s = r;
    end
  endtask

  task sysx(input logic w, input logic dbg, input logic [31:0] a,
            input logic [31:0] wd);
    sys_req <= 1'b1;
    sys_in <= '{we: w, dbg: dbg, addr: a, wdata: wd};
    @(posedge pclk);
    for (k = 0; k < 1000 && sys_ack !== 1'b1; k++)
      @(posedge pclk);
    if (k == 1000)
      n_errors++;
    e = sys_err;
    r = sys_rdata;
    sys_req <= 1'b0;
    @(posedge pclk);
  endtask

  task chk_nv;
    apb(1'b0, `FNPC_OFS_LOCK, 32'h0);
    chk("lock", {16'h0, m_lock}, r);
    chk("bod", {31'h0, m_gp[0]}, {31'h0, bod_en});
    chk("bor", {31'h0, m_gp[1]}, {31'h0, bor_en});
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    summarize();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, sys_req} = '0;
    {fpp_valid, wipe_pin, test_mode_pin, port_line_zero} = '0;
    port_line_one = 1'b0;
    sys_in = '0;
    fpp_cmd = '0;
    nv_init = '{lock: 16'h0002, gp: 2'h0, sec: 1'b0, cal: CAL};
    m_lock = 16'h0002;
    m_gp = 2'h0;
    seed = 32'hd6f7e3a3;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, `FNPC_OFS_MODE, 32'h0);
    chk("mode", `FNPC_MODE_RST, r);
    chk_nv();
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    sys_in <= '{we: 1'b0, dbg: 1'b0, addr: 32'h0, wdata: 32'h0};
    @(posedge pclk);
    chk("alias", 32'h1, {30'h0, dec_sram, dec_flash});
    cmd(`FNPC_OP_SLB, 9'd0, 8'h00);
    wait_rdy();
    chk("keyerr", 32'h1, {31'h0, s[3]});
    chk_nv();
    test_mode_pin <= 1'b1;
    port_line_zero <= 1'b1;
    port_line_one <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("fpp_mode", 32'h1, {31'h0, fpp_mode});
    fpp_cmd <= '{op: `FNPC_OP_SLB, page: 9'd64};
    fpp_valid <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 100 && fpp_ready !== 1'b1; k++)
      @(posedge pclk);
    fpp_valid <= 1'b0;
    {test_mode_pin, port_line_zero, port_line_one} <= 3'h0;
    m_lock[2] = 1'b1;
    wait_rdy();
    chk_nv();
    cmd(`FNPC_OP_PE, 9'd40, `FNPC_KEY);
    wait_rdy();
    chk("lockerr", 32'h1, {31'h0, s[2]});
    cmd(`FNPC_OP_CLB, 9'd32, `FNPC_KEY);
    m_lock[1] = 1'b0;
    wait_rdy();
    chk_nv();
    for (int i = 0; i < 32; i++)
    begin
      d = $random(seed);
      bufw[i] = d;
      sysx(1'b1, 1'b0, FB + 32'd384 + i * 4, d);
    end
    cmd(`FNPC_OP_WP, 9'd3, `FNPC_KEY);
    wait_rdy();
    // Back-to-back words of two lines: the second of each comes from prefetch
    for (int i = 0; i < 4; i++)
    begin
      sysx(1'b0, 1'b0, (i < 2 ? 32'h0 : FB) + 32'd384 + i * 4, 32'h0);
      chk("rdata", bufw[i], r);
    end
    chk("standby", 32'h0, {31'h0, arr_en});
    for (int i = 0; i < 3; i++)
    begin
      cmd(i == 2 ? `FNPC_OP_CGP : `FNPC_OP_SGP, i[8:0] & 9'h1, `FNPC_KEY);
      m_gp[i & 1] = (i != 2);
      wait_rdy();
      chk_nv();
    end
    cmd(`FNPC_OP_SSB, 9'd0, `FNPC_KEY);
    wait_rdy();
    chk("sec", 32'h1, {31'h0, s[4]});
    sysx(1'b0, 1'b1, FB + 32'd388, 32'h0);
    chk("dbg_refused", 32'h1, {31'h0, e});
    sysx(1'b0, 1'b0, FB + 32'd388, 32'h0);
    chk("cpu_allowed", 32'h0, {31'h0, e});
    // Wipe held only through the erase; the long hold is cut for run time
    wipe_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    wait_rdy();
    wipe_pin <= 1'b0;
    m_lock = 16'h0;
    m_gp = 2'h0;
    chk_nv();
    apb(1'b0, `FNPC_OFS_NVM, 32'h0);
    chk("nvm", {8'h0, CAL, 16'h0}, r);
    sysx(1'b0, 1'b1, FB + 32'd416, 32'h0);
    chk("wiped", 32'hffff_ffff, r);
    apb(1'b1, `FNPC_OFS_MODE, 32'h000f_1003);
    apb(1'b0, `FNPC_OFS_MODE, 32'h0);
    chk("mode_ws", 32'h000f_1003, r);
    sys_in <= '{we: 1'b0, dbg: 1'b0, addr: 32'h0, wdata: 32'h0};
    @(posedge pclk);
    chk("remap", 32'h2, {30'h0, dec_sram, dec_flash});
    sysx(1'b0, 1'b0, FB + 32'd432, 32'h0);
    chk("ws3_read", 32'hffff_ffff, r);
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1'b1, `FNPC_OFS_MODE, 32'h000f_1203);
    cmd(`FNPC_OP_SLB, 9'd0, 8'h00);
    chk("irq_err", 32'h1, {31'h0, irq});
    summarize();
  end
endmodule
